// ### verilog/gcc_top.sv
// Operation
// - Top two gain bits shift all four decimated currents: gain 1, 2, 4 or 8.
// - Low fourteen bits carry two-bit analog gain codes per voltage and current input.
// - Analog code 00 is 1x, 01 is 2x, 10 is 4x; code 11 is invalid.
// - Checksum low byte is the eight-bit sum of all guarded bytes.
// - Checksum high byte is the exclusive-or of all guarded bytes.
// - Checksum recomputed continuously; compared while start register holds the check value.
// - Mismatch sets fault flag bit 14 and warning pin; interrupt pin only while mask bit 14 is set.
//
// Added by the designer: the Wishbone interface to the registers.
`timescale 1ns/100ps
`default_nettype none
`include "gcc_defs.svh"

module gcc_top
	import gcc_pkg::*;
(
	// Clock and reset.
	input  wire logic                          clk_i,
	input  wire logic                          rst_i,
	// Wishbone classic slave.
	input  wire logic                          wb_cyc_i,
	input  wire logic                          wb_stb_i,
	input  wire logic                          wb_we_i,
	input  wire logic [31:0]                   wb_adr_i,
	input  wire logic [3:0]                    wb_sel_i,
	input  wire logic [31:0]                   wb_dat_i,
	output logic      [31:0]                   wb_dat_o,
	output logic                               wb_ack_o,
	// Decimated current samples, one lane per channel.
	input  wire logic                          cur_valid_i,
	input  wire logic [4*`GCC_SAMPLE_W-1:0]    cur_sample_i,
	output logic                               cur_valid_o,
	output logic      [4*`GCC_SAMPLE_W-1:0]    cur_sample_o,
	// Analog amplifier gain codes and alarm pins.
	output logic      [13:0]                   analog_gain_codes_o,
	output logic                               warning_output_pin_o,
	output logic                               irq_o
);

	localparam int W = `GCC_SAMPLE_W;

	// True when an index falls inside the guarded configuration block.
	function automatic logic in_cfg_block(input logic [7:0] idx);
		in_cfg_block = (idx >= `GCC_IDX_CFG_FIRST) && (idx <= `GCC_IDX_CFG_LAST);
	endfunction

	// Slot of a guarded word inside the storage array.
	function automatic logic [`GCC_CFG_SLOT_W-1:0] cfg_slot(input logic [7:0] idx);
		logic [7:0] d;
		d = idx - `GCC_IDX_CFG_FIRST;
		cfg_slot = d[`GCC_CFG_SLOT_W-1:0];
	endfunction

	// Byte-lane merge of a 16-bit register with a write.
	function automatic logic [15:0] merge16(input logic [15:0] old,
	                                        input logic [31:0] wdat,
	                                        input logic [3:0]  sel);
		merge16[7:0]  = sel[0] ? wdat[7:0]  : old[7:0];
		merge16[15:8] = sel[1] ? wdat[15:8] : old[15:8];
	endfunction

	// Signed left shift by zero to three places that clips instead of wrapping.
	function automatic logic [W-1:0] sat_shift(input logic [W-1:0] x,
	                                           input logic [1:0]   s);
		logic [W+2:0] ext;
		logic [W+2:0] sh;
		logic         ovf;
		ext = {{3{x[W-1]}}, x};
		sh  = ext << s;
		ovf = !((sh[W+2:W-1] == '0) || (sh[W+2:W-1] == '1));
		if (ovf) begin
			sat_shift = x[W-1] ? {1'b1, {(W-1){1'b0}}} : {1'b0, {(W-1){1'b1}}};
		end else begin
			sat_shift = sh[W-1:0];
		end
	endfunction

	// Register state.
	logic [15:0]     cfg_reg       [`GCC_CFG_WORDS];
	logic [15:0]     cfg_next      [`GCC_CFG_WORDS];
	logic [15:0]     start_reg;
	logic [15:0]     start_next;
	logic [15:0]     cs_reg;
	logic [15:0]     cs_next;
	logic [15:0]     status_reg;
	logic [15:0]     status_next;
	logic [15:0]     mask_reg;
	logic [15:0]     mask_next;
	logic            ack_reg;
	logic            ack_next;
	logic [31:0]     rdat_reg;
	logic [31:0]     rdat_next;

	// Checksum scanner state.
	gcc_scan_t                  scan_reg;
	gcc_scan_t                  scan_next;
	logic [`GCC_CFG_SLOT_W-1:0] idx_reg;
	logic [`GCC_CFG_SLOT_W-1:0] idx_next;
	logic [7:0]                 sum_reg;
	logic [7:0]                 sum_next;
	logic [7:0]                 xor_reg;
	logic [7:0]                 xor_next;
	logic [15:0]                calc_reg;
	logic [15:0]                calc_next;
	logic                       mismatch;

	// Bus decode shared by the register process.
	logic [7:0]      bus_idx;
	logic            bus_req;
	logic            bus_wr;
	logic            bus_rd;
	logic [15:0]     rd_word;

	assign bus_idx = wb_adr_i[9:2];
	assign bus_req = wb_cyc_i && wb_stb_i;
	// Writes and read side effects act at the edge that samples ack high.
	assign bus_wr  = bus_req && wb_we_i && ack_reg;
	assign bus_rd  = bus_req && !wb_we_i && ack_reg;

	// Read multiplexer; unmapped indices read as zero.
	always_comb begin
		rd_word = 16'h0000;
		if (in_cfg_block(bus_idx)) begin
			rd_word = cfg_reg[cfg_slot(bus_idx)];
		end else begin
			case (bus_idx)
				`GCC_IDX_STATUS0:   rd_word = status_reg;
				`GCC_IDX_MASK0:     rd_word = mask_reg;
				`GCC_IDX_CALC_CS:   rd_word = calc_reg;
				`GCC_IDX_CFG_START: rd_word = start_reg;
				`GCC_IDX_CHECKSUM:  rd_word = cs_reg;
				default:            rd_word = 16'h0000;
			endcase
		end
	end

	// Scanner walks one guarded word per cycle, then latches and compares.
	// A write during a pass can give one stale result; the next pass corrects it.
	always_comb begin
		scan_next = scan_reg;
		idx_next  = idx_reg;
		sum_next  = sum_reg;
		xor_next  = xor_reg;
		calc_next = calc_reg;
		mismatch  = 1'b0;
		case (scan_reg)
			GCC_SCAN: begin
				sum_next = sum_reg + cfg_reg[idx_reg][15:8] + cfg_reg[idx_reg][7:0];
				xor_next = xor_reg ^ cfg_reg[idx_reg][15:8] ^ cfg_reg[idx_reg][7:0];
				if (idx_reg == `GCC_CFG_SLOT_W'(`GCC_CFG_WORDS - 1)) begin
					scan_next = GCC_LATCH;
				end else begin
					idx_next = idx_reg + `GCC_CFG_SLOT_W'(1);
				end
			end
			GCC_LATCH: begin
				calc_next = {xor_reg, sum_reg};
				scan_next = GCC_CMP;
			end
			GCC_CMP: begin
				mismatch  = (start_reg == `GCC_CHECK_VALUE) && (calc_reg != cs_reg);
				idx_next  = '0;
				sum_next  = 8'h00;
				xor_next  = 8'h00;
				scan_next = GCC_SCAN;
			end
			default: begin
				idx_next  = '0;
				sum_next  = 8'h00;
				xor_next  = 8'h00;
				scan_next = GCC_SCAN;
			end
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			scan_reg <= GCC_SCAN;
			idx_reg  <= '0;
			sum_reg  <= 8'h00;
			xor_reg  <= 8'h00;
			calc_reg <= 16'h0000;
		end else begin
			scan_reg <= scan_next;
			idx_reg  <= idx_next;
			sum_reg  <= sum_next;
			xor_reg  <= xor_next;
			calc_reg <= calc_next;
		end
	end

	// Register file next state, bus answer and fault flag.
	always_comb begin
		for (int i = 0; i < `GCC_CFG_WORDS; i++) begin
			cfg_next[i] = cfg_reg[i];
		end
		start_next = start_reg;
		cs_next    = cs_reg;
		mask_next  = mask_reg;
		status_next = status_reg;
		ack_next   = bus_req && !ack_reg;
		rdat_next  = rdat_reg;
		if (bus_req && !ack_reg && !wb_we_i) begin
			rdat_next = {16'h0000, rd_word};
		end
		if (bus_wr) begin
			if (in_cfg_block(bus_idx)) begin
				cfg_next[cfg_slot(bus_idx)] = merge16(cfg_reg[cfg_slot(bus_idx)],
				                                      wb_dat_i, wb_sel_i);
			end else begin
				case (bus_idx)
					`GCC_IDX_CFG_START: start_next = merge16(start_reg, wb_dat_i, wb_sel_i);
					`GCC_IDX_CHECKSUM:  cs_next    = merge16(cs_reg, wb_dat_i, wb_sel_i);
					`GCC_IDX_MASK0:     mask_next  = merge16(mask_reg, wb_dat_i, wb_sel_i);
					default:            ;
				endcase
			end
		end
		// A read of the status word clears it; a fault in the same cycle still sets.
		if (bus_rd && (bus_idx == `GCC_IDX_STATUS0)) begin
			status_next = 16'h0000;
		end
		if (mismatch) begin
			status_next[`GCC_FAULT_BIT] = 1'b1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cfg_reg[0] <= `GCC_RST_CFG_31;
			cfg_reg[1] <= `GCC_RST_CFG_32;
			cfg_reg[2] <= `GCC_RST_CFG_33;
			cfg_reg[3] <= `GCC_RST_GAIN_CFG;
			for (int i = 4; i < `GCC_CFG_WORDS; i++) begin
				cfg_reg[i] <= `GCC_RST_CFG_OTHER;
			end
			start_reg  <= `GCC_RST_CFG_START;
			cs_reg     <= `GCC_RST_CHECKSUM;
			status_reg <= 16'h0000;
			mask_reg   <= 16'h0000;
			ack_reg    <= 1'b0;
			rdat_reg   <= 32'h0000_0000;
		end else begin
			for (int i = 0; i < `GCC_CFG_WORDS; i++) begin
				cfg_reg[i] <= cfg_next[i];
			end
			start_reg  <= start_next;
			cs_reg     <= cs_next;
			status_reg <= status_next;
			mask_reg   <= mask_next;
			ack_reg    <= ack_next;
			rdat_reg   <= rdat_next;
		end
	end

	assign wb_ack_o = ack_reg;
	assign wb_dat_o = rdat_reg;

	// Pins follow the sticky flag, the interrupt only while mask bit 14 is set, so a short mismatch is never missed.
	assign warning_output_pin_o = status_reg[`GCC_FAULT_BIT];
	assign irq_o                = |(status_reg & mask_reg);

	// Analog codes go out untouched; code 11 is passed through, not repaired.
	assign analog_gain_codes_o =
		cfg_reg[cfg_slot(`GCC_IDX_GAIN_CFG)][`GCC_AGAIN_HI:`GCC_AGAIN_LO];

	// Digital gain on the decimated currents, one pipeline stage.
	logic [1:0]                    dgain;
	logic [4*`GCC_SAMPLE_W-1:0]    samp_reg;
	logic [4*`GCC_SAMPLE_W-1:0]    samp_next;
	logic                          sval_reg;
	logic                          sval_next;

	assign dgain = cfg_reg[cfg_slot(`GCC_IDX_GAIN_CFG)][`GCC_DGAIN_HI:`GCC_DGAIN_LO];

	generate
		for (genvar ch = 0; ch < `GCC_CUR_CHANNELS; ch++) begin : g_lane
			always_comb begin
				samp_next[ch*W +: W] = samp_reg[ch*W +: W];
				if (cur_valid_i) begin
					samp_next[ch*W +: W] = sat_shift(cur_sample_i[ch*W +: W], dgain);
				end
			end
		end
	endgenerate

	assign sval_next = cur_valid_i;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			samp_reg <= '0;
			sval_reg <= 1'b0;
		end else begin
			samp_reg <= samp_next;
			sval_reg <= sval_next;
		end
	end

	assign cur_sample_o = samp_reg;
	assign cur_valid_o  = sval_reg;

endmodule

`default_nettype wire

// ### verilog/gcc_defs.svh
`ifndef GCC_DEFS_SVH
`define GCC_DEFS_SVH

// Register indices; the byte address on the bus is four times the index.
`define GCC_IDX_STATUS0     8'h01
`define GCC_IDX_MASK0       8'h02
`define GCC_IDX_CALC_CS     8'h03
`define GCC_IDX_CFG_START   8'h30
`define GCC_IDX_CFG_FIRST   8'h31
`define GCC_IDX_GAIN_CFG    8'h34
`define GCC_IDX_CFG_LAST    8'h3A
`define GCC_IDX_CHECKSUM    8'h3B

// Number of words guarded by the checksum.
`define GCC_CFG_WORDS       10
`define GCC_CFG_SLOT_W      4

// Reset values.
`define GCC_RST_CFG_START   16'h0000
`define GCC_RST_CFG_31      16'h0000
`define GCC_RST_CFG_32      16'hC468
`define GCC_RST_CFG_33      16'h0087
`define GCC_RST_GAIN_CFG    16'h0000
`define GCC_RST_CFG_OTHER   16'h0000
`define GCC_RST_CHECKSUM    16'h421C

// Value of the start register that arms the comparison.
`define GCC_CHECK_VALUE     16'h8765

// Field positions.
`define GCC_DGAIN_HI        15
`define GCC_DGAIN_LO        14
`define GCC_AGAIN_HI        13
`define GCC_AGAIN_LO        0
`define GCC_FAULT_BIT       14

// Width of one decimated current sample.
`define GCC_SAMPLE_W        24
`define GCC_CUR_CHANNELS    4

`endif

// ### verilog/gcc_pkg.sv
package gcc_pkg;

	// Checksum scanner states; one bit changes per step except from GCC_CMP back to GCC_SCAN.
	typedef enum logic [1:0] {
		GCC_SCAN  = 2'b00,
		GCC_LATCH = 2'b01,
		GCC_CMP   = 2'b11
	} gcc_scan_t;

endpackage

// ### test/gcc_top_monitor.sv
`timescale 1ns/100ps
`default_nettype none

module gcc_top_monitor (
	// Clock and reset.
	input wire logic        clk_i,
	input wire logic        rst_i,
	// Register bus.
	input wire logic        wb_cyc_i,
	input wire logic        wb_stb_i,
	input wire logic        wb_we_i,
	input wire logic [31:0] wb_adr_i,
	input wire logic        wb_ack_o,
	// Sample path and pins.
	input wire logic        cur_valid_i,
	input wire logic [95:0] cur_sample_i,
	input wire logic        cur_valid_o,
	input wire logic [95:0] cur_sample_o,
	input wire logic [13:0] analog_gain_codes_o,
	input wire logic        warning_output_pin_o,
	input wire logic        irq_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);

	// A request is taken only while no answer is standing.
	sequence bus_req;
		wb_cyc_i && wb_stb_i && !wb_ack_o;
	endsequence
	// The warning pin was high and has just gone low.
	sequence warn_drop;
		warning_output_pin_o ##1 !warning_output_pin_o;
	endsequence

	// Answered status reads and gain-word writes, kept as plain conditions so $past can see them.
	logic status_rd;
	logic gain_wr;
	assign status_rd = wb_ack_o && !wb_we_i && (wb_adr_i[9:2] == 8'h01);
	assign gain_wr   = wb_ack_o && wb_we_i && (wb_adr_i[9:2] == 8'h34);

	ack_latency_a: assert property (bus_req |=> wb_ack_o) else $error("ack late");
	ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
	ack_cause_a: assert property (!$past(wb_stb_i) |-> !wb_ack_o) else $error("ack unasked");
	sample_valid_a: assert property (cur_valid_i |=> cur_valid_o) else $error("sample lost");
	zero_sample_a: assert property (cur_valid_i && (cur_sample_i == 96'h0)
		|=> cur_sample_o == 96'h0) else $error("zero scaled");
	sample_hold_a: assert property (!cur_valid_o |-> $stable(cur_sample_o))
		else $error("sample moved");
	codes_write_a: assert property ($changed(analog_gain_codes_o) |-> $past(gain_wr))
		else $error("codes moved");
	irq_fault_a: assert property (irq_o |-> warning_output_pin_o) else $error("irq alone");
	warn_sticky_a: assert property (warn_drop |-> $past(status_rd))
		else $error("warn dropped");
endmodule

`default_nettype wire

// ### test/gcc_top_tb.sv
`timescale 1ns/100ps
`default_nettype none

module gcc_top_tb;
	logic        clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, cur_valid_i;
	logic        wb_ack_o, cur_valid_o, warning_output_pin_o, irq_o;
	logic [31:0] wb_adr_i, wb_dat_i, wb_dat_o;
	logic [3:0]  wb_sel_i;
	logic [95:0] cur_sample_i, cur_sample_o, smp;
	logic [13:0] analog_gain_codes_o;
	logic [31:0] rdq[$];
	logic [95:0] smq[$];
	logic [15:0] w;
	logic [7:0]  sum, x;
	int          mismatches, checks, seed;

	gcc_top dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
		.wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
		.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .cur_valid_i(cur_valid_i),
		.cur_sample_i(cur_sample_i), .cur_valid_o(cur_valid_o), .cur_sample_o(cur_sample_o),
		.analog_gain_codes_o(analog_gain_codes_o), .warning_output_pin_o(warning_output_pin_o),
		.irq_o(irq_o));

	task automatic check(input logic [95:0] got, input logic [95:0] exp);
		checks++;
		if (got !== exp) begin
			mismatches++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic finish_test;
		$display("mismatches %0d checks %0d", mismatches, checks);
		if (mismatches == 0 && checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask

	// One classic cycle; a read notes its expected data for the watcher.
	task automatic bus(input logic we, input logic [7:0] idx, input logic [15:0] d,
		input logic [15:0] exp);
		if (!we) rdq.push_back({16'h0000, exp});
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i  <= we;
		wb_adr_i <= {22'h000000, idx, 2'b00};
		wb_dat_i <= {16'h0000, d};
		// Only the watchdog ends a wait that never gets its answer.
		do begin
			@(posedge clk_i);
		end while (wb_ack_o !== 1'b1);
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		@(posedge clk_i);
	endtask

	// Software never programs the invalid analog code, so such draws are moved to 4x.
	function automatic logic [15:0] legal_codes(input logic [15:0] v);
		legal_codes = v;
		for (int k = 0; k < 14; k += 2) begin
			if (legal_codes[k+:2] == 2'b11) legal_codes[k+:2] = 2'b10;
		end
	endfunction

	// Expected lanes: signed shift, clamped instead of wrapped.
	function automatic logic [95:0] scale(input logic [95:0] s, input logic [1:0] c);
		logic signed [26:0] v;
		scale = '0;
		for (int i = 0; i < 4; i++) begin
			v = $signed(s[24*i+:24]) <<< c;
			if (v > $signed(27'h07FFFFF)) scale[24*i+:24] = 24'h7FFFFF;
			else if (v < $signed(27'h7800000)) scale[24*i+:24] = 24'h800000;
			else scale[24*i+:24] = v[23:0];
		end
	endfunction

	// Free running clock.
	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end

	// Watcher pairs each read answer with the oldest note.
	always @(posedge clk_i) begin
		if (wb_ack_o && !wb_we_i && rdq.size() > 0) check(wb_dat_o, rdq.pop_front());
		if (cur_valid_o && smq.size() > 0) check(cur_sample_o, smq.pop_front());
	end

	// A hang is cut short long after the sequence should be over.
	initial begin
		#100us;
		mismatches++;
		finish_test;
	end

	initial begin
		{rst_i, wb_cyc_i, wb_stb_i, wb_we_i, cur_valid_i} <= 5'h10;
		{wb_adr_i, wb_dat_i, cur_sample_i} <= '0;
		wb_sel_i <= 4'hF;
		seed = 32'h7dd0894a;
		repeat (12) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		bus(0, 8'h34, 0, 16'h0000);
		bus(0, 8'h3B, 0, 16'h421C);
		bus(0, 8'h20, 0, 16'h0000);
		for (int c = 0; c < 4; c++) begin
			w = legal_codes(16'($random(seed)));
			w[15:14] = c[1:0];
			bus(1, 8'h34, w, 0);
			check(analog_gain_codes_o, w[13:0]);
			repeat (2) begin
				smp = {$random(seed), $random(seed), $random(seed)};
				cur_valid_i <= 1'b1;
				cur_sample_i <= smp;
				smq.push_back(scale(smp, c[1:0]));
				@(posedge clk_i);
			end
			cur_sample_i <= '0;
			@(posedge clk_i);
			cur_valid_i <= 1'b0;
			smq.push_back('0);
			@(posedge clk_i);
		end
		{sum, x} = '0;
		for (int i = 0; i < 10; i++) begin
			w = legal_codes(16'($random(seed)));
			bus(1, 8'h31 + 8'(i), w, 0);
			sum = sum + w[15:8] + w[7:0];
			x = x ^ w[15:8] ^ w[7:0];
		end
		bus(1, 8'h3B, {x, sum} ^ 16'h0001, 0);
		bus(1, 8'h02, 16'h4000, 0);
		repeat (30) @(posedge clk_i);
		check(warning_output_pin_o, 1'b0);
		bus(1, 8'h30, 16'h8765, 0);
		repeat (30) @(posedge clk_i);
		bus(0, 8'h03, 0, {x, sum});
		check({warning_output_pin_o, irq_o}, 2'b11);
		bus(1, 8'h02, 16'h0000, 0);
		check(irq_o, 1'b0);
		bus(1, 8'h02, 16'h4000, 0);
		bus(1, 8'h3B, {x, sum}, 0);
		repeat (30) @(posedge clk_i);
		bus(0, 8'h01, 0, 16'h4000);
		repeat (2) @(posedge clk_i);
		check({warning_output_pin_o, irq_o}, 2'b00);
		bus(0, 8'h01, 0, 16'h0000);
		finish_test;
	end
endmodule

bind gcc_top gcc_top_monitor mon (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
	.wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_ack_o(wb_ack_o),
	.cur_valid_i(cur_valid_i), .cur_sample_i(cur_sample_i), .cur_valid_o(cur_valid_o),
	.cur_sample_o(cur_sample_o), .analog_gain_codes_o(analog_gain_codes_o),
	.warning_output_pin_o(warning_output_pin_o), .irq_o(irq_o));

`default_nettype wire
